// *** logic/sdp_consts.svh ***
// Constants of the segment descriptor protection unit
`ifndef SDP_CONSTS_SVH
`define SDP_CONSTS_SVH

// ****************************************
// Exception codes
// ****************************************
`define SDP_EXC_GP      8'h0D
`define SDP_EXC_NP      8'h0B

// ****************************************
// Descriptor type codes
// ****************************************
`define SDP_TYPE_LTAB   4'h2
`define SDP_TYPE_CALL   4'h4
`define SDP_TYPE_TASK   4'h5
`define SDP_TYPE_INTR   4'h6
`define SDP_TYPE_TRAP   4'h7
`define SDP_GATE_GROUP  2'h1

// ****************************************
// Segment register slots and levels
// ****************************************
`define SDP_SEG_CS      2'h0
`define SDP_SEG_SS      2'h1
`define SDP_SEG_DATA    2'h2
`define SDP_SEG_EXT     2'h3
`define SDP_LVL_TOP     2'h0

// ****************************************
// Entry geometry and reset values
// ****************************************
`define SDP_ENTRY_FIRST 3'h0
`define SDP_ENTRY_LAST  3'h7
`define SDP_LVL_RST     2'h0
`define SDP_BASE_RST    24'h00_0000
`define SDP_LIMIT_RST   16'h0000

`endif

// *** logic/sdp_pkg.sv ***
// Types of the segment descriptor protection unit
package sdp_pkg;

  typedef enum logic [1:0] {SDP_IDLE = 2'b00, SDP_FETCH = 2'b01} sdp_fsm_t;
  typedef enum logic [1:0] {SDP_OP_SEG = 2'b00, SDP_OP_LTAB = 2'b01, SDP_OP_GATE = 2'b10} sdp_op_t;

  typedef struct packed {
    logic [12:0] index;
    logic        tableSelectBit;
    logic [1:0]  requestedLevelField;
  } sdp_sel_t;

  typedef struct packed {
    logic       present;
    logic [1:0] descriptorLevelField;
    logic       isSegment;
    logic [3:0] descType;
  } sdp_access_t;

  typedef struct packed {
    sdp_access_t access;
    logic [39:0] body;
  } sdp_raw_desc_t;

  typedef struct packed {
    logic [23:0] base;
    logic [15:0] limit;
  } sdp_table_t;

  typedef struct packed {
    logic [2:0]  reserved;
    logic [4:0]  wordCount;
    sdp_sel_t    targetSel;
    logic [15:0] offset;
  } sdp_gate_body_t;

  typedef struct packed {
    logic [7:0]  reserved;
    sdp_table_t  table_;
  } sdp_tbl_operand_t;

  typedef struct packed {
    logic        valid;
    sdp_sel_t    sel;
    sdp_access_t access;
    sdp_table_t  span;
  } sdp_cache_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  gateType;
    logic [1:0]  descriptorLevelField;
    logic [4:0]  wordCount;
    sdp_sel_t    targetSel;
    logic [15:0] offset;
    logic        targetIsTask;
  } sdp_gate_t;

  typedef struct packed {
    sdp_fsm_t         fsm;
    sdp_op_t          op;
    logic [1:0]       segIdx;
    sdp_sel_t         sel;
    logic             viaVector;
    sdp_cache_t [3:0] cache;
    sdp_table_t       gt;
    sdp_table_t       lt;
    sdp_table_t       vt;
    logic [1:0]       lvl;
    logic [1:0]       effLevel;
    logic             memReq;
    logic [23:0]      memAddr;
    logic             done;
    logic             excValid;
    logic [7:0]       excCode;
    sdp_gate_t        gate;
    logic             xlatValid;
    logic             xlatFault;
    logic [23:0]      xlatAddr;
  } sdp_state_t;

endpackage

// *** logic/sdp_protection_unit.sv ***
// Segment selector decode, descriptor tables, segment caches and privilege level
// What this block does
// RL1 - Four segment caches reload on selector load
// RL2 - Only segment descriptors enter a cache
// RL3 - Accesses use cached base, limit, access data
// RL4 - Caches hidden, change only on segment load
// RL5 - Gate valid flag marks contents valid
// RL6 - Word count 0-31, call gates only
// RL7 - Gate selector targets code or task block
// RL8 - Selector: level 1-0, table bit 2, index
// RL9 - Tables hold 8192 entries, 13-bit index
// RL10 - Each table: 24-bit base, 16-bit limit
// RL11 - Fetch beyond table limit raises exception 13
// RL12 - Global table rejects interrupt and trap gates
// RL13 - Local table: segments, task, call gates
// RL14 - Table loads only at privilege level 0
// RL15 - Global load takes six-byte limit, base operand
// RL16 - Local load reads base, limit from descriptor
// RL17 - Vector table holds task, interrupt, trap gates
// RL18 - Vector load: privileged, six-byte operand
// RL19 - Software sizes vector table 256 bytes minimum
// RL20 - Four levels, zero most privileged
// RL21 - Current level is code selector low bits
// RL22 - Task start level from its code selector
// RL23 - Invalid gate reference raises exception 11
// RL24 - Effective level is max of requested, current
`timescale 1ns/1ps
`include "sdp_consts.svh"

module sdp_protection_unit (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // Segment register load
  input  wire logic                     segLoadReq,
  input  wire logic [1:0]               segLoadIdx,
  input  wire sdp_pkg::sdp_sel_t        segLoadSel,
  // Table loads
  input  wire logic                     gtLoadReq,
  input  wire logic                     vtLoadReq,
  input  wire sdp_pkg::sdp_tbl_operand_t tblOperand,
  input  wire logic                     ltLoadReq,
  input  wire sdp_pkg::sdp_sel_t        ltLoadSel,
  // Gate lookup
  input  wire logic                     gateReq,
  input  wire logic                     gateFromVector,
  input  wire logic [7:0]               gateVector,
  input  wire sdp_pkg::sdp_sel_t        gateSel,
  // Descriptor memory
  output logic                          memReq,
  output logic [23:0]                   memAddr,
  input  wire logic                     memValid,
  input  wire sdp_pkg::sdp_raw_desc_t   memData,
  // Address translation
  input  wire logic                     xlatReq,
  input  wire logic [1:0]               xlatIdx,
  input  wire logic [15:0]              xlatOffset,
  output logic                          xlatValid,
  output logic                          xlatFault,
  output logic [23:0]                   xlatAddr,
  // Results
  output logic                          done,
  output logic                          excValid,
  output logic [7:0]                    excCode,
  output logic [1:0]                    currentPrivilegeLevel,
  output logic [1:0]                    effectiveLevel,
  output sdp_pkg::sdp_gate_t            gateInfo
);
  import sdp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  sdp_state_t     st_r;
  sdp_state_t     st_nxt;

  logic           idle;
  logic           takeTbl;
  logic           takeLt;
  logic           takeSeg;
  logic           takeGate;
  logic           outOfRange;
  logic           fetchDone;
  logic           gateTypeOk;
  logic           expandDown;
  logic           xlatBad;
  logic [23:0]    lookAddr;
  sdp_sel_t       lookSel;
  sdp_table_t     lookTbl;
  sdp_access_t    acc;
  sdp_table_t     segBody;
  sdp_gate_body_t gateBody;
  sdp_cache_t     xlatEntry;

  // ****************************************
  // Request selection and table lookup
  // ****************************************
  assign idle     = (st_r.fsm == SDP_IDLE);
  assign takeTbl  = idle & (gtLoadReq | vtLoadReq);
  assign takeLt   = idle & ~(gtLoadReq | vtLoadReq) & ltLoadReq;
  assign takeSeg  = idle & ~(gtLoadReq | vtLoadReq | ltLoadReq) & segLoadReq;
  assign takeGate = idle & ~(gtLoadReq | vtLoadReq | ltLoadReq | segLoadReq) & gateReq;

  // Vector number stands in as an index into the vector table
  assign lookSel = takeLt ? ltLoadSel :
                   takeSeg ? segLoadSel :
                   gateFromVector ? sdp_sel_t'({5'h00, gateVector, 3'h0}) : gateSel; // [RL8]
  assign lookTbl = (takeGate & gateFromVector) ? st_r.vt :
                   (lookSel.tableSelectBit & ~takeLt) ? st_r.lt : st_r.gt; // [RL8]
  // Last byte of the 8-byte entry must sit inside the limit
  assign outOfRange = {lookSel.index, `SDP_ENTRY_LAST} > lookTbl.limit; // [RL11] [RL19]
  assign lookAddr   = lookTbl.base + {8'h00, lookSel.index, `SDP_ENTRY_FIRST}; // [RL9]

  // ****************************************
  // Fetched descriptor decode
  // ****************************************
  assign fetchDone = (st_r.fsm == SDP_FETCH) & memValid;
  assign acc       = memData.access;
  assign segBody   = sdp_table_t'(memData.body);
  assign gateBody  = sdp_gate_body_t'(memData.body);
  always_comb begin
    gateTypeOk = ~acc.isSegment & (acc.descType[3:2] == `SDP_GATE_GROUP);
    if (st_r.viaVector) begin
      gateTypeOk = gateTypeOk & (acc.descType != `SDP_TYPE_CALL); // [RL17]
    end else if (st_r.sel.tableSelectBit) begin
      gateTypeOk = gateTypeOk & ((acc.descType == `SDP_TYPE_CALL) | (acc.descType == `SDP_TYPE_TASK)); // [RL13]
    end else begin
      gateTypeOk = gateTypeOk & (acc.descType != `SDP_TYPE_INTR) & (acc.descType != `SDP_TYPE_TRAP); // [RL12]
    end
  end

  // ****************************************
  // Translation through cached descriptors
  // ****************************************
  assign xlatEntry  = st_r.cache[xlatIdx];
  assign expandDown = xlatEntry.access.isSegment & ~xlatEntry.access.descType[3] & xlatEntry.access.descType[2];
  // An empty cache means no descriptor backs the segment
  assign xlatBad    = ~xlatEntry.valid |
                      (expandDown ? (xlatOffset <= xlatEntry.span.limit) : (xlatOffset > xlatEntry.span.limit)); // [RL3]

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt           = st_r;
    st_nxt.done      = 1'b0;
    st_nxt.excValid  = 1'b0;
    st_nxt.gate.valid = 1'b0;
    st_nxt.xlatValid = xlatReq;
    st_nxt.xlatFault = xlatReq & xlatBad;
    if (xlatReq) begin
      st_nxt.xlatAddr = xlatEntry.span.base + {8'h00, xlatOffset}; // [RL3]
    end
    case (st_r.fsm)
      SDP_IDLE: begin
        if (takeTbl) begin
          st_nxt.done = 1'b1;
          if (st_r.lvl != `SDP_LVL_TOP) begin
            st_nxt.excValid = 1'b1; // [RL14]
            st_nxt.excCode  = `SDP_EXC_GP;
          end else if (gtLoadReq) begin
            st_nxt.gt = tblOperand.table_; // [RL15] [RL10]
          end else begin
            st_nxt.vt = tblOperand.table_; // [RL18] [RL10]
          end
        end else if (takeLt | takeSeg | takeGate) begin
          if (takeSeg) begin
            // Numerically larger level is the less trusted one
            st_nxt.effLevel = (segLoadSel.requestedLevelField > st_r.lvl) ?
                              segLoadSel.requestedLevelField : st_r.lvl; // [RL24] [RL20]
          end
          if ((takeLt & (st_r.lvl != `SDP_LVL_TOP)) | (takeLt & ltLoadSel.tableSelectBit) | outOfRange) begin
            st_nxt.done     = 1'b1; // [RL11] [RL14]
            st_nxt.excValid = 1'b1;
            st_nxt.excCode  = `SDP_EXC_GP;
          end else begin
            st_nxt.fsm       = SDP_FETCH;
            st_nxt.memReq    = 1'b1;
            st_nxt.memAddr   = lookAddr;
            st_nxt.sel       = lookSel;
            st_nxt.segIdx    = segLoadIdx;
            st_nxt.viaVector = takeGate & gateFromVector;
            st_nxt.op        = takeLt ? SDP_OP_LTAB : (takeSeg ? SDP_OP_SEG : SDP_OP_GATE);
          end
        end
      end
      SDP_FETCH: begin
        if (memValid) begin
          st_nxt.fsm    = SDP_IDLE;
          st_nxt.memReq = 1'b0;
          st_nxt.done   = 1'b1;
          case (st_r.op)
            SDP_OP_SEG: begin
              if (!acc.isSegment) begin
                st_nxt.excValid = 1'b1; // [RL2]
                st_nxt.excCode  = `SDP_EXC_GP;
              end else if (!acc.present) begin
                st_nxt.excValid = 1'b1;
                st_nxt.excCode  = `SDP_EXC_NP;
              end else begin
                st_nxt.cache[st_r.segIdx] = '{1'b1, st_r.sel, acc, segBody}; // [RL1] [RL4]
                if (st_r.segIdx == `SDP_SEG_CS) begin
                  st_nxt.lvl = st_r.sel.requestedLevelField; // [RL21] [RL22]
                end
              end
            end
            SDP_OP_LTAB: begin
              if (acc.isSegment | (acc.descType != `SDP_TYPE_LTAB)) begin
                st_nxt.excValid = 1'b1;
                st_nxt.excCode  = `SDP_EXC_GP;
              end else if (!acc.present) begin
                st_nxt.excValid = 1'b1;
                st_nxt.excCode  = `SDP_EXC_NP;
              end else begin
                st_nxt.lt = segBody; // [RL16] [RL10]
              end
            end
            SDP_OP_GATE: begin
              if (!gateTypeOk) begin
                st_nxt.excValid = 1'b1; // [RL12] [RL13] [RL17]
                st_nxt.excCode  = `SDP_EXC_GP;
              end else if (!acc.present) begin
                st_nxt.excValid = 1'b1; // [RL5] [RL23]
                st_nxt.excCode  = `SDP_EXC_NP;
              end else begin
                st_nxt.gate.valid                = 1'b1; // [RL5]
                st_nxt.gate.gateType             = acc.descType;
                st_nxt.gate.descriptorLevelField = acc.descriptorLevelField;
                st_nxt.gate.wordCount = (acc.descType == `SDP_TYPE_CALL) ? gateBody.wordCount : 5'h00; // [RL6]
                st_nxt.gate.targetSel            = gateBody.targetSel; // [RL7]
                st_nxt.gate.offset               = gateBody.offset; // [RL7]
                st_nxt.gate.targetIsTask         = (acc.descType == `SDP_TYPE_TASK); // [RL7]
              end
            end
            default: st_nxt.op = SDP_OP_SEG;
          endcase
        end
      end
      default: st_nxt.fsm = SDP_IDLE;
    endcase
    if (!rst_n) begin
      st_nxt          = '0;
      st_nxt.fsm      = SDP_IDLE;
      st_nxt.op       = SDP_OP_SEG;
      st_nxt.lvl      = `SDP_LVL_RST;
      st_nxt.gt       = '{`SDP_BASE_RST, `SDP_LIMIT_RST};
      st_nxt.lt       = '{`SDP_BASE_RST, `SDP_LIMIT_RST};
      st_nxt.vt       = '{`SDP_BASE_RST, `SDP_LIMIT_RST};
    end
  end

  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign memReq                = st_r.memReq;
  assign memAddr               = st_r.memAddr;
  assign xlatValid             = st_r.xlatValid;
  assign xlatFault             = st_r.xlatFault;
  assign xlatAddr              = st_r.xlatAddr;
  assign done                  = st_r.done;
  assign excValid              = st_r.excValid;
  assign excCode               = st_r.excCode;
  assign currentPrivilegeLevel = st_r.lvl;
  assign effectiveLevel        = st_r.effLevel;
  assign gateInfo              = st_r.gate;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_cache_only_on_load;
    !(fetchDone && st_r.op == SDP_OP_SEG) |=> $stable(st_r.cache);
  endproperty
  a_cache_only_on_load: assert property (p_cache_only_on_load) else $error("cache changed without load"); // [RL4]

  property p_seg_type;
    fetchDone && st_r.op == SDP_OP_SEG && !acc.isSegment |=> excValid && excCode == `SDP_EXC_GP && $stable(st_r.cache);
  endproperty
  a_seg_type: assert property (p_seg_type) else $error("system descriptor reached a cache"); // [RL2]

  property p_gate_np;
    fetchDone && st_r.op == SDP_OP_GATE && gateTypeOk && !acc.present |=> excValid && excCode == `SDP_EXC_NP;
  endproperty
  a_gate_np: assert property (p_gate_np) else $error("invalid gate not faulted"); // [RL23]

  property p_gate_valid;
    gateInfo.valid |-> $past(acc.present) && !excValid;
  endproperty
  a_gate_valid: assert property (p_gate_valid) else $error("gate reported from invalid entry"); // [RL5]

  property p_word_count;
    gateInfo.valid && gateInfo.gateType != `SDP_TYPE_CALL |-> gateInfo.wordCount == 5'h00;
  endproperty
  a_word_count: assert property (p_word_count) else $error("word count on non-call gate"); // [RL6]

  property p_limit;
    takeSeg && outOfRange |=> excValid && excCode == `SDP_EXC_GP && !memReq;
  endproperty
  a_limit: assert property (p_limit) else $error("fetch beyond limit"); // [RL11]

  property p_priv;
    takeTbl && st_r.lvl != `SDP_LVL_TOP |=> excValid && excCode == `SDP_EXC_GP && $stable(st_r.gt) && $stable(st_r.vt);
  endproperty
  a_priv: assert property (p_priv) else $error("table load outside level 0"); // [RL14]

  property p_lvl;
    $changed(st_r.lvl) |-> $past(fetchDone && st_r.op == SDP_OP_SEG && st_r.segIdx == `SDP_SEG_CS);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level changed without code load"); // [RL21]

  property p_eff;
    takeSeg |=> effectiveLevel == (($past(segLoadSel.requestedLevelField) > $past(st_r.lvl)) ?
                                   $past(segLoadSel.requestedLevelField) : $past(st_r.lvl));
  endproperty
  a_eff: assert property (p_eff) else $error("effective level wrong"); // [RL24]

  property p_xlat;
    xlatReq |=> xlatValid && xlatAddr == $past(xlatEntry.span.base) + {8'h00, $past(xlatOffset)};
  endproperty
  a_xlat: assert property (p_xlat) else $error("translation not from cache"); // [RL3]

  property p_vec_call;
    fetchDone && st_r.op == SDP_OP_GATE && st_r.viaVector && acc.descType == `SDP_TYPE_CALL |=>
      excValid && excCode == `SDP_EXC_GP;
  endproperty
  a_vec_call: assert property (p_vec_call) else $error("call gate taken from vector table"); // [RL17]

  property p_fetch_addr;
    takeSeg && !outOfRange |=> memReq && memAddr == $past(lookTbl.base) + {8'h00, $past(segLoadSel.index), 3'h0};
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("descriptor address wrong"); // [RL9]

  c_seg_ok: cover property (fetchDone && st_r.op == SDP_OP_SEG ##1 done && !excValid);
  c_gate_ok: cover property (gateInfo.valid);
  c_lt_ok: cover property (fetchDone && st_r.op == SDP_OP_LTAB ##1 !excValid);
  c_gp: cover property (excValid && excCode == `SDP_EXC_GP);

endmodule

// *** verification/sdp_desc_memory.sv ***
// Descriptor table memory that answers the unit's descriptor fetches
`timescale 1ns/1ps

module sdp_desc_memory (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // Fetch port
  input  wire logic                   memReq,
  input  wire logic [23:0]            memAddr,
  output logic                        memValid,
  output sdp_pkg::sdp_raw_desc_t      memData,
  // Latency choice
  input  wire logic                   slow
);
  import sdp_pkg::*;

  logic [47:0] tbl [int];
  logic [47:0] lastWord;
  logic [2:0]  waitCnt;
  logic        served;

  // Idle bus shows the inverted last word, so stale data fails
  always_comb begin
    memData = memValid ? sdp_raw_desc_t'(tbl[int'(memAddr)]) : sdp_raw_desc_t'(~lastWord);
  end

  // One pulse per request, after zero or three wait cycles
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      memValid <= 1'b0;
      waitCnt  <= 3'h0;
      served   <= 1'b0;
      lastWord <= 48'h0000_0000_0000;
    end else if (memValid) begin
      memValid <= 1'b0;
      lastWord <= memData;
    end else if (!memReq) begin
      served  <= 1'b0;
      waitCnt <= 3'h0;
    end else if (!served) begin
      if (waitCnt >= (slow ? 3'h3 : 3'h0)) begin
        memValid <= 1'b1;
        served   <= 1'b1;
      end else begin
        waitCnt <= waitCnt + 3'h1;
      end
    end
  end
endmodule

// *** verification/sdp_protection_unit_test.sv ***
// Self-checking bench of the segment descriptor protection unit
`timescale 1ns/1ps
`include "sdp_consts.svh"

module sdp_protection_unit_test;
  import sdp_pkg::*;

  logic             clock, rst_n, segLoadReq, gtLoadReq, vtLoadReq, ltLoadReq, gateReq, gateFromVector;
  logic             xlatReq, slow, memReq, memValid, xlatValid, xlatFault, done, excValid;
  logic [1:0]       segLoadIdx, xlatIdx, currentPrivilegeLevel, effectiveLevel;
  logic [7:0]       gateVector, excCode, ec;
  logic [15:0]      xlatOffset, off;
  logic [23:0]      memAddr, xlatAddr, fa;
  sdp_sel_t         segLoadSel, ltLoadSel, gateSel;
  sdp_tbl_operand_t tblOperand;
  sdp_raw_desc_t    memData;
  sdp_gate_t        gateInfo, gi;
  logic [4:0]       wcA [12];
  logic [15:0]      selA [12], offA [12];
  int               num_errors, num_checks, seed, i, t, ty;

  sdp_protection_unit dut (.clock(clock), .rst_n(rst_n), .segLoadReq(segLoadReq), .segLoadIdx(segLoadIdx),
    .segLoadSel(segLoadSel), .gtLoadReq(gtLoadReq), .vtLoadReq(vtLoadReq), .tblOperand(tblOperand),
    .ltLoadReq(ltLoadReq), .ltLoadSel(ltLoadSel), .gateReq(gateReq), .gateFromVector(gateFromVector),
    .gateVector(gateVector), .gateSel(gateSel), .memReq(memReq), .memAddr(memAddr), .memValid(memValid),
    .memData(memData), .xlatReq(xlatReq), .xlatIdx(xlatIdx), .xlatOffset(xlatOffset), .xlatValid(xlatValid),
    .xlatFault(xlatFault), .xlatAddr(xlatAddr), .done(done), .excValid(excValid), .excCode(excCode),
    .currentPrivilegeLevel(currentPrivilegeLevel), .effectiveLevel(effectiveLevel), .gateInfo(gateInfo));
  sdp_desc_memory mem (.clock(clock), .rst_n(rst_n), .memReq(memReq), .memAddr(memAddr),
    .memValid(memValid), .memData(memData), .slow(slow));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ****************************************
  // Expectations and bus tasks
  // ****************************************
  function automatic sdp_sel_t mksel(input int idx, input logic ts, input int lvl);
    return {13'(idx), ts, 2'(lvl)};
  endfunction
  // S=1: writable data segment, S=0: local table descriptor
  function automatic logic [47:0] segd(input logic p, input logic s, input logic [23:0] b, input logic [15:0] l);
    return {p, 2'h0, s, 4'h2, b, l};
  endfunction
  function automatic logic [23:0] gaddr(input int tn, input int gt);
    if (tn == 0) return 24'h01_0000 + 24'(gt * 8);
    if (tn == 1) return 24'h03_0000 + 24'((gt - 3) * 8);
    return 24'h05_0000 + 24'((gt + 28) * 8);
  endfunction
  function automatic logic [7:0] gexp(input int tn, input int gt, input logic p);
    if ((tn < 2 && gt >= 6) || (tn == 2 && gt == 4)) return `SDP_EXC_GP;
    return p ? 8'h00 : `SDP_EXC_NP;
  endfunction

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Caller raised the request; drop it after the taking edge
  task automatic run();
    int n;
    fa = 24'hFF_FFFF;
    slow = 1'($random(seed));
    @(negedge clock);
    {segLoadReq, gtLoadReq, vtLoadReq, ltLoadReq, gateReq} = 5'h00;
    for (n = 0; n < 20 && done !== 1'b1; n++) begin
      if (memReq === 1'b1) fa = memAddr;
      @(negedge clock);
    end
    check("done", 48'(done), 48'h1);
    ec = (excValid === 1'b1) ? excCode : 8'h00;
    gi = gateInfo;
    @(negedge clock);
  endtask

  task automatic seg(input logic [1:0] idx, input sdp_sel_t s);
    segLoadIdx = idx;
    segLoadSel = s;
    segLoadReq = 1'b1;
    run();
  endtask

  task automatic tload(input logic g, input logic [23:0] b, input logic [15:0] l);
    tblOperand = {8'h00, b, l};
    gtLoadReq = g;
    vtLoadReq = !g;
    run();
  endtask

  task automatic xlat(input logic [1:0] idx, input logic [15:0] o, input logic flt, input logic [23:0] ad);
    xlatIdx = idx;
    xlatOffset = o;
    xlatReq = 1'b1;
    @(negedge clock);
    xlatReq = 1'b0;
    check("xlatValid", 48'(xlatValid), 48'h1);
    check("xlatFault", 48'(xlatFault), 48'(flt));
    if (!flt) check("xlatAddr", 48'(xlatAddr), 48'(ad));
    @(negedge clock);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    summarize();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 32'h38e8;
    {rst_n, segLoadReq, gtLoadReq, vtLoadReq, ltLoadReq, gateReq, gateFromVector, xlatReq, slow, segLoadIdx,
      segLoadSel, tblOperand, ltLoadSel, gateVector, gateSel, xlatIdx, xlatOffset} = '0;
    mem.tbl[32'h01_0008] = segd(1'b1, 1'b1, 24'h20_0000, 16'h0FFF);
    mem.tbl[32'h01_0010] = segd(1'b0, 1'b1, 24'h21_0000, 16'h0FFF);
    mem.tbl[32'h01_0018] = segd(1'b1, 1'b0, 24'h03_0000, 16'h003F);
    mem.tbl[32'h01_0040] = {1'b0, 2'h0, 1'b0, `SDP_TYPE_CALL, 40'h00_0000_0000};
    mem.tbl[32'h01_0048] = {8'h96, 24'h30_0000, 16'h00FF};
    mem.tbl[32'h01_00F8] = segd(1'b1, 1'b1, 24'h22_0000, 16'h00FF);
    mem.tbl[32'h03_0000] = segd(1'b1, 1'b1, 24'h40_0000, 16'h7FFF);
    mem.tbl[32'h05_07F8] = {1'b1, 2'h0, 1'b0, `SDP_TYPE_TASK, 40'h00_0000_0000};
    for (i = 0; i < 12; i++) begin
      wcA[i] = 5'($random(seed));
      selA[i] = 16'($random(seed));
      offA[i] = 16'($random(seed));
      mem.tbl[int'(gaddr(i / 4, 4 + i % 4))] = {1'b1, 2'(i), 1'b0, 4'(4 + i % 4), 3'h0, wcA[i], selA[i], offA[i]};
    end
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    check("resetOut", 48'({memReq, done, excValid, currentPrivilegeLevel}), 48'h0);
    xlat(`SDP_SEG_DATA, 16'h0000, 1'b1, 24'h00_0000);
    $display("test reset done");

    tload(1'b1, 24'h01_0000, 16'h00FF);
    check("gtLoad", 48'(ec), 48'h0);
    tload(1'b0, 24'h05_0000, 16'h07FF);
    check("vtLoad", 48'(ec), 48'h0);
    ltLoadSel = mksel(3, 1'b0, 0);
    ltLoadReq = 1'b1;
    run();
    check("ltFetch", 48'({fa, ec}), 48'({24'h01_0018, 8'h00}));
    ltLoadSel = mksel(3, 1'b1, 0);
    ltLoadReq = 1'b1;
    run();
    check("ltBadSel", 48'(ec), 48'(`SDP_EXC_GP));
    $display("test tables done");

    seg(`SDP_SEG_DATA, mksel(1, 1'b0, 2));
    check("dataFetch", 48'({fa, ec}), 48'({24'h01_0008, 8'h00}));
    check("effLevel", 48'(effectiveLevel), 48'h2);
    for (i = 0; i < 8; i++) begin
      off = (i == 0) ? 16'h0FFF : (i == 1) ? 16'h1000 : 16'($random(seed));
      xlat(`SDP_SEG_DATA, off, off > 16'h0FFF, 24'h20_0000 + 24'(off));
    end
    seg(`SDP_SEG_EXT, mksel(8, 1'b0, 0));
    check("gateInCache", 48'(ec), 48'(`SDP_EXC_GP));
    seg(`SDP_SEG_EXT, mksel(2, 1'b0, 0));
    check("notPresent", 48'(ec), 48'(`SDP_EXC_NP));
    xlat(`SDP_SEG_EXT, 16'h0000, 1'b1, 24'h00_0000);
    seg(`SDP_SEG_DATA, mksel(32, 1'b0, 0));
    check("pastLimit", 48'({fa, ec}), 48'({24'hFF_FFFF, `SDP_EXC_GP}));
    xlat(`SDP_SEG_DATA, 16'h0010, 1'b0, 24'h20_0010);
    seg(`SDP_SEG_EXT, mksel(31, 1'b0, 0));
    check("lastEntry", 48'({fa, ec}), 48'({24'h01_00F8, 8'h00}));
    seg(`SDP_SEG_SS, mksel(0, 1'b1, 0));
    check("ltSeg", 48'({fa, ec}), 48'({24'h03_0000, 8'h00}));
    xlat(`SDP_SEG_SS, 16'h7FFF, 1'b0, 24'h40_7FFF);
    seg(`SDP_SEG_EXT, mksel(9, 1'b0, 0));
    xlat(`SDP_SEG_EXT, 16'h00FF, 1'b1, 24'h00_0000);
    xlat(`SDP_SEG_EXT, 16'h0100, 1'b0, 24'h30_0100);
    $display("test segments done");

    for (i = 0; i < 12; i++) begin
      t = i / 4;
      ty = 4 + i % 4;
      gateFromVector = (t == 2);
      gateVector = 8'(ty + 28);
      gateSel = mksel((t == 0) ? ty : ty - 3, t == 1, 0);
      gateReq = 1'b1;
      run();
      check("gateAddr", 48'(fa), 48'(gaddr(t, ty)));
      check("gateExc", 48'(ec), 48'(gexp(t, ty, 1'b1)));
      if (gexp(t, ty, 1'b1) == 8'h00) begin
        check("gateValid", 48'(gi.valid), 48'h1);
        check("gateFields", 48'({gi.gateType, gi.descriptorLevelField, gi.targetSel, gi.offset, gi.targetIsTask}),
              48'({4'(ty), 2'(i), selA[i], offA[i], ty == 5}));
        check("wordCount", 48'(gi.wordCount), 48'((ty == 4) ? wcA[i] : 5'h00));
      end
    end
    gateFromVector = 1'b0;
    gateSel = mksel(8, 1'b0, 0);
    gateReq = 1'b1;
    run();
    check("gateInvalid", 48'(ec), 48'(`SDP_EXC_NP));
    gateFromVector = 1'b1;
    gateVector = 8'hFF;
    gateReq = 1'b1;
    run();
    check("vector255", 48'({fa, ec}), 48'({24'h05_07F8, 8'h00}));
    $display("test gates done");

    seg(`SDP_SEG_CS, mksel(1, 1'b0, 3));
    check("lvlFromCode", 48'(currentPrivilegeLevel), 48'h3);
    seg(`SDP_SEG_DATA, mksel(1, 1'b0, 1));
    check("effMax", 48'(effectiveLevel), 48'h3);
    tload(1'b1, 24'h01_0000, 16'h00FF);
    check("gtAtLevel3", 48'(ec), 48'(`SDP_EXC_GP));
    ltLoadSel = mksel(3, 1'b0, 0);
    ltLoadReq = 1'b1;
    run();
    check("ltAtLevel3", 48'(ec), 48'(`SDP_EXC_GP));
    seg(`SDP_SEG_CS, mksel(1, 1'b0, 0));
    check("lvlBack", 48'(currentPrivilegeLevel), 48'h0);
    tload(1'b0, 24'h05_0000, 16'h07FF);
    check("vtAtLevel0", 48'(ec), 48'h0);
    $display("test privilege done");
    summarize();
  end
endmodule
